// ==== src/bil_consts.vh ====
// constants for the boot image loader with crc check
// assumes a 100 MHz ref_clk and byte-wide boot stream
// Functional notes
// R1: image opens with 32-bit word count, then that many 4-byte program words
// R2: length and check word are assembled least significant byte first
// R3: check word follows program; 0x0d15ab1e skips crc verification
// R4: program words go to ram from lowest address upward
// R5: after loading, execution starts at lowest ram address
// R6: crc covers length bytes then program bytes, not the check word
// R7: crc uses reflected polynomial 0xedb88320 per byte
// R8: crc accumulator preset to all ones before first length byte
// R9: accumulator inverted after last program byte, compared with check word
// R10: otp is four sectors of 512 rows of 32 bits
// R11: security register loaded from otp at power-up first
// R12: remaining otp copied to sram and run before any other program
// R13: crc mismatch with check enabled: do not start, flag boot error
`ifndef BIL_CONSTS_VH
`define BIL_CONSTS_VH
`define BIL_CRC_POLY     32'hedb88320
`define BIL_CRC_PRESET   32'hffffffff
`define BIL_NO_CRC_MAGIC 32'h0d15ab1e
`define BIL_OTP_SECTORS  4
`define BIL_OTP_ROWS     512
`define BIL_OTP_WIDTH    32
`define BIL_SEC_ROW      11'h000
`define BIL_RAM_BASE     20'h00000
`define BIL_FIFO_DEPTH   16
`endif

// ==== src/bil_fifo.v ====
// synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
module bil_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge ref_clk) begin
      if (push)
         mem[wr_q] <= in_data;
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         if (push & ~pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

// ==== src/bil_loader.v ====
// boot loader: otp copy at power-up, then byte-stream image load with crc
// assumes otp and ram are synchronous memories with one-cycle read data,
// and the processor starts only on exec_start
`timescale 1ns/10ps
`include "bil_consts.vh"
module bil_loader #(
   parameter RAM_AW = 20,
   parameter OTP_AW = 11
) (
   input  wire              ref_clk,
   input  wire              rst,
   input  wire [7:0]        src_data,
   input  wire              src_valid,
   output wire              src_ready,
   output reg  [OTP_AW-1:0] otp_addr_q,
   output reg               otp_rd_q,
   input  wire [31:0]       otp_rdata,
   output reg  [31:0]       sec_cfg_q,
   output reg               sec_valid_q,
   output reg  [RAM_AW-1:0] ram_addr_q,
   output reg  [31:0]       ram_wdata_q,
   output reg               ram_we_q,
   output reg               exec_start_q,
   output reg  [RAM_AW-1:0] exec_addr_q,
   output reg               otp_code_q,
   output reg               boot_err_q,
   output reg               boot_done_q,
   output reg               crc_skip_q
);
   localparam OTP_ROWS = `BIL_OTP_SECTORS * `BIL_OTP_ROWS; // [R10]

   // otp copy states first, then stream load states
   localparam S_SEC   = 3'd0;
   localparam S_OTP   = 3'd1;
   localparam S_OTPX  = 3'd2;
   localparam S_LEN   = 3'd3;
   localparam S_PROG  = 3'd4;
   localparam S_CHK   = 3'd5;
   localparam S_DONE  = 3'd6;
   localparam S_FAIL  = 3'd7;

   reg  [2:0]        st_q;
   reg  [31:0]       crc_q;
   reg  [31:0]       sh_q;
   reg  [1:0]        bcnt_q;
   reg  [31:0]       words_q;
   reg  [OTP_AW:0]   orow_q;
   reg               orow_vld_q;
   wire [7:0]        f_data;
   wire              f_valid;
   wire              f_take;
   wire [31:0]       crc_nx;
   wire [31:0]       word_nx;
   wire              otp_idle;
   wire              otp_data_rdy;
   reg  [31:0]       c;
   integer           i;

   // bytes arriving during the otp copy wait here;
   // the source stalls once the fifo is full
   bil_fifo #(
      .WIDTH (8),
      .DEPTH (`BIL_FIFO_DEPTH),
      .AW    (4)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_data   (src_data),
      .in_valid  (src_valid),
      .in_ready  (src_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_take)
   );

   // stream is drained only while loading; in the otp phase the source stalls once the fifo fills
   assign f_take = f_valid & ((st_q == S_LEN) | (st_q == S_PROG) |
                              (st_q == S_CHK));

   // otp read data is valid the cycle after the read pulse
   assign otp_idle     = ~orow_vld_q & ~otp_rd_q;
   assign otp_data_rdy = orow_vld_q & ~otp_rd_q;

   // bytewise reflected crc
   always @* begin
      c = crc_q ^ {24'h000000, f_data};
      for (i = 0; i < 8; i = i + 1) begin
         c = c[0] ? ((c >> 1) ^ `BIL_CRC_POLY) : (c >> 1); // [R7]
      end
   end
   assign crc_nx  = c;
   assign word_nx = {f_data, sh_q[31:8]}; // lsb first [R2]

   always @(posedge ref_clk) begin
      if (rst) begin
         st_q         <= S_SEC;
         crc_q        <= `BIL_CRC_PRESET;
         sh_q         <= 32'h00000000;
         bcnt_q       <= 2'd0;
         words_q      <= 32'h00000000;
         orow_q       <= {(OTP_AW+1){1'b0}};
         orow_vld_q   <= 1'b0;
         otp_addr_q   <= `BIL_SEC_ROW;
         otp_rd_q     <= 1'b0;
         sec_cfg_q    <= 32'h00000000;
         sec_valid_q  <= 1'b0;
         ram_addr_q   <= `BIL_RAM_BASE;
         ram_wdata_q  <= 32'h00000000;
         ram_we_q     <= 1'b0;
         exec_start_q <= 1'b0;
         exec_addr_q  <= `BIL_RAM_BASE;
         otp_code_q   <= 1'b0;
         boot_err_q   <= 1'b0;
         boot_done_q  <= 1'b0;
         crc_skip_q   <= 1'b0;
      end else begin
         ram_we_q     <= 1'b0;
         exec_start_q <= 1'b0;
         otp_rd_q     <= 1'b0;
         case (st_q)
            S_SEC: begin
               // security row read first, before anything runs [R11]
               if (otp_idle) begin
                  otp_rd_q   <= 1'b1;
                  otp_addr_q <= `BIL_SEC_ROW;
                  orow_vld_q <= 1'b1;
               end else if (otp_data_rdy) begin
                  sec_cfg_q   <= otp_rdata;
                  sec_valid_q <= 1'b1;
                  orow_vld_q  <= 1'b0;
                  orow_q      <= {{OTP_AW{1'b0}}, 1'b1};
                  ram_addr_q  <= `BIL_RAM_BASE;
                  st_q        <= S_OTP;
               end
            end
            S_OTP: begin
               // copy remaining rows into sram [R12]
               // a row takes three cycles: read, data back, write
               if (ram_we_q)
                  ram_addr_q <= ram_addr_q + 1'b1;
               if (otp_data_rdy) begin
                  ram_wdata_q <= otp_rdata;
                  ram_we_q    <= 1'b1;
                  orow_vld_q  <= 1'b0;
               end
               if (otp_idle) begin
                  if (orow_q == OTP_ROWS[OTP_AW:0]) begin
                     exec_addr_q  <= `BIL_RAM_BASE;
                     exec_start_q <= 1'b1; // otp code runs first [R12]
                     otp_code_q   <= 1'b1;
                     st_q         <= S_OTPX;
                  end else begin
                     otp_addr_q <= orow_q[OTP_AW-1:0];
                     otp_rd_q   <= 1'b1;
                     orow_vld_q <= 1'b1;
                     orow_q     <= orow_q + 1'b1;
                  end
               end
            end
            S_OTPX: begin
               // stream crc restarts only after the otp copy has run
               otp_code_q <= 1'b0;
               crc_q      <= `BIL_CRC_PRESET; // [R8]
               bcnt_q     <= 2'd0;
               ram_addr_q <= `BIL_RAM_BASE; // [R4]
               st_q       <= S_LEN;
            end
            // zero length skips straight to the check word
            S_LEN: if (f_take) begin
               crc_q  <= crc_nx; // [R6]
               sh_q   <= word_nx;
               bcnt_q <= bcnt_q + 1'b1;
               if (bcnt_q == 2'd3) begin
                  words_q <= word_nx; // [R1]
                  st_q    <= (word_nx == 32'h00000000) ? S_CHK : S_PROG;
               end
            end
            S_PROG: begin
               // address steps after each write, ready for the next word
               if (ram_we_q)
                  ram_addr_q <= ram_addr_q + 1'b1; // [R4]
               if (f_take) begin
                  crc_q  <= crc_nx; // [R6]
                  sh_q   <= word_nx;
                  bcnt_q <= bcnt_q + 1'b1;
                  if (bcnt_q == 2'd3) begin
                     ram_wdata_q <= word_nx;
                     ram_we_q    <= 1'b1;
                     words_q     <= words_q - 1'b1;
                     if (words_q == 32'h00000001)
                        st_q <= S_CHK;
                  end
               end
            end
            S_CHK: if (f_take) begin
               // check word not folded into crc [R6]
               // magic word wins, so a skipped image never flags an error
               sh_q   <= word_nx;
               bcnt_q <= bcnt_q + 1'b1;
               if (bcnt_q == 2'd3) begin
                  if (word_nx == `BIL_NO_CRC_MAGIC) begin // [R3]
                     crc_skip_q <= 1'b1;
                     st_q       <= S_DONE;
                  end else if (word_nx == ~crc_q) begin // [R9]
                     st_q <= S_DONE;
                  end else begin
                     boot_err_q <= 1'b1; // [R13]
                     st_q       <= S_FAIL;
                  end
               end
            end
            // one start pulse; done then holds until reset
            S_DONE: if (!boot_done_q) begin
               boot_done_q  <= 1'b1;
               exec_addr_q  <= `BIL_RAM_BASE; // [R5]
               exec_start_q <= 1'b1;
            end
            S_FAIL: st_q <= S_FAIL; // held until reset [R13]
            default: st_q <= S_FAIL;
         endcase
      end
   end
endmodule

// ==== verification/bil_loader_props.sv ====
// assertions on the boot image loader ports
// assumes one clock domain and synchronous active-high rst
`timescale 1ns/10ps
module bil_loader_chk #(
   parameter RAM_AW = 20,
   parameter OTP_AW = 11
) (
   input logic              ref_clk,
   input logic              rst,
   input logic [OTP_AW-1:0] otp_addr_q,
   input logic              otp_rd_q,
   input logic              sec_valid_q,
   input logic              ram_we_q,
   input logic              exec_start_q,
   input logic [RAM_AW-1:0] exec_addr_q,
   input logic              otp_code_q,
   input logic              boot_err_q,
   input logic              boot_done_q,
   input logic              crc_skip_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_exec_addr; exec_start_q |-> exec_addr_q == '0; endproperty
   a_exec_addr: assert property (p_exec_addr) else $error("bad start");
   property p_pulse; exec_start_q |=> !exec_start_q; endproperty
   a_pulse: assert property (p_pulse) else $error("long start");
   property p_err_nogo;
      boot_err_q |-> !exec_start_q && !boot_done_q;
   endproperty
   a_err_nogo: assert property (p_err_nogo) else $error("err start");
   property p_err_hold; boot_err_q |=> boot_err_q; endproperty
   a_err_hold: assert property (p_err_hold) else $error("err lost");
   property p_sec_first; ram_we_q || exec_start_q |-> sec_valid_q; endproperty
   a_sec_first: assert property (p_sec_first) else $error("no sec");
   property p_sec_row;
      $rose(sec_valid_q) |-> $past(otp_rd_q, 2) && $past(otp_addr_q, 2) == '0;
   endproperty
   a_sec_row: assert property (p_sec_row) else $error("sec row");
   property p_code_go; otp_code_q |-> exec_start_q; endproperty
   a_code_go: assert property (p_code_go) else $error("code go");
   property p_done_go; exec_start_q && !otp_code_q |-> ##[0:1] boot_done_q;
   endproperty
   a_done_go: assert property (p_done_go) else $error("not done");
   property p_skip_ok; crc_skip_q |-> !boot_err_q; endproperty
   a_skip_ok: assert property (p_skip_ok) else $error("skip err");
   property p_rd_pulse; otp_rd_q |=> !otp_rd_q; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("long read");
endmodule
bind bil_loader bil_loader_chk #(.RAM_AW(RAM_AW), .OTP_AW(OTP_AW))
   u_bil_loader_chk (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .otp_addr_q   (otp_addr_q),
      .otp_rd_q     (otp_rd_q),
      .sec_valid_q  (sec_valid_q),
      .ram_we_q     (ram_we_q),
      .exec_start_q (exec_start_q),
      .exec_addr_q  (exec_addr_q),
      .otp_code_q   (otp_code_q),
      .boot_err_q   (boot_err_q),
      .boot_done_q  (boot_done_q),
      .crc_skip_q   (crc_skip_q)
   );

// ==== verification/bil_src_model.sv ====
// boot source and otp memory model
// assumes the bench pushes image bytes into q
`timescale 1ns/10ps
module bil_src_model (
   input  logic        ref_clk,
   input  logic        src_ready,
   input  logic        otp_rd_q,
   input  logic [10:0] otp_addr_q,
   output logic [7:0]  src_data,
   output logic        src_valid,
   output logic [31:0] otp_rdata
);
   logic [7:0] q [$];
   initial begin
      src_valid = 0;
      src_data = 0;
      otp_rdata = 0;
   end
   always @(posedge ref_clk) begin
      if (src_valid && src_ready) q.delete(0);
      src_valid <= q.size() != 0;
      // released lines flip so stale data never looks valid
      src_data <= q.size() != 0 ? q[0] : ~src_data;
      otp_rdata <= otp_rd_q ? {21'h0a5a5a, otp_addr_q} : ~otp_rdata;
   end
endmodule

// ==== verification/tb_top.sv ====
// bench for the boot image loader
// assumes bil_loader, its fifo and the source model are compiled first
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
   logic        ref_clk = 0, rst = 1;
   logic [7:0]  src_data;
   logic        src_valid, src_ready, otp_rd_q, sec_valid_q, ram_we_q;
   logic        exec_start_q, otp_code_q, boot_err_q, boot_done_q, crc_skip_q;
   logic [10:0] otp_addr_q;
   logic [31:0] otp_rdata, sec_cfg_q, ram_wdata_q, crc;
   logic [19:0] ram_addr_q, exec_addr_q;
   int          err_count = 0, compares = 0;
   bil_loader u_bil_loader (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .src_data     (src_data),
      .src_valid    (src_valid),
      .src_ready    (src_ready),
      .otp_addr_q   (otp_addr_q),
      .otp_rd_q     (otp_rd_q),
      .otp_rdata    (otp_rdata),
      .sec_cfg_q    (sec_cfg_q),
      .sec_valid_q  (sec_valid_q),
      .ram_addr_q   (ram_addr_q),
      .ram_wdata_q  (ram_wdata_q),
      .ram_we_q     (ram_we_q),
      .exec_start_q (exec_start_q),
      .exec_addr_q  (exec_addr_q),
      .otp_code_q   (otp_code_q),
      .boot_err_q   (boot_err_q),
      .boot_done_q  (boot_done_q),
      .crc_skip_q   (crc_skip_q)
   );
   bil_src_model u_bil_src_model (
      .ref_clk    (ref_clk),
      .src_ready  (src_ready),
      .otp_rd_q   (otp_rd_q),
      .otp_addr_q (otp_addr_q),
      .src_data   (src_data),
      .src_valid  (src_valid),
      .otp_rdata  (otp_rdata)
   );
   always #5 ref_clk = ~ref_clk;
   function automatic [31:0] crc_b(input [31:0] c, input [7:0] b);
      c = c ^ b;
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
      return c;
   endfunction
   task automatic do_reset;
      @(posedge ref_clk);
      rst <= 1;
      repeat (2) @(posedge ref_clk);
      rst <= 0;
      #1;
   endtask
   task automatic put(input [31:0] w, input bit crc_it);
      for (int i = 0; i < 4; i++) begin
         u_bil_src_model.q.push_back(w[8*i +: 8]);
         if (crc_it) crc = crc_b(crc, w[8*i +: 8]);
      end
   endtask
   task automatic otp_phase(input bit rdy);
      int we;
      bit seen;
      logic [31:0] exp_row;
      we = 0;
      seen = 0;
      repeat (8000) if (!seen) begin
         @(posedge ref_clk);
         #1;
         if (ram_we_q) begin
            exp_row = {21'h0a5a5a, we[10:0] + 11'h1};
            `CHK("otp_row", we[19:0], ram_addr_q)
            `CHK("otp_dat", exp_row, ram_wdata_q)
            we++;
         end
         seen = exec_start_q;
      end
      `CHK("otp_go", 1'b1, otp_code_q)
      `CHK("otp_rows", 2047, we)
      `CHK("sec_cfg", {21'h0a5a5a, 11'h000}, sec_cfg_q)
      `CHK("sec_valid", 1'b1, sec_valid_q)
      `CHK("ready", rdy, src_ready)
   endtask
   task automatic image(input int n, input int mode, input bit early);
      logic [31:0] w [$];
      logic [31:0] chk_w;
      int k;
      bit go;
      k = 0;
      go = 0;
      crc = 32'hffffffff;
      do_reset;
      if (!early) otp_phase(1);
      put(n, 1);
      for (int i = 0; i < n; i++) begin
         w.push_back(32'hc0de0000 + i * 32'h01010101);
         put(w[i], 1);
      end
      // a bad check word differs from the true one in one bit only
      chk_w = ~crc ^ (mode == 2 ? 32'h00000100 : 32'h00000000);
      put(mode == 1 ? 32'h0d15ab1e : chk_w, 0);
      if (early) otp_phase(0);
      repeat (200) begin
         @(posedge ref_clk);
         #1;
         if (ram_we_q) begin
            `CHK("ram_addr", k[19:0], ram_addr_q)
            `CHK("ram_data", w[k], ram_wdata_q)
            k++;
         end
         if (exec_start_q) go = 1;
         if (exec_start_q) `CHK("exec_addr", 20'h00000, exec_addr_q)
      end
      `CHK("words", n, k)
      `CHK("start", mode != 2, go)
      `CHK("done", mode != 2, boot_done_q)
      `CHK("err", mode == 2, boot_err_q)
      `CHK("skip", mode == 1, crc_skip_q)
   endtask
   task automatic t_good; image(3, 0, 0); $display("good image done"); endtask
   task automatic t_skip; image(0, 1, 0); $display("skip image done"); endtask
   task automatic t_bad; image(2, 2, 1); $display("bad image done"); endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      t_good;
      t_skip;
      t_bad;
      complete_run;
   end
   initial begin
      #600000;
      err_count++;
      complete_run;
   end
endmodule
